// ===== hw/rtcb_core.sv
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module rtcb_core
  import rtcb_pkg::*;
#(
  parameter longint REC_CYCLES = RTCB_REC_CYCLES,
  parameter int OSC_HZ = RTCB_OSC_HZ
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic osc_in,
  input wire logic supply_ok_in,
  output logic rst_pin_o,
  output logic rst_pin_oe,
  output logic osc_fail_irq_n,
  input wire logic xfer_start,
  input wire logic xfer_end,
  input wire logic ptr_load,
  input wire logic [4:0] ptr_val,
  input wire logic ptr_inc,
  input wire logic wr_stb,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  output logic [4:0] ptr
);
  localparam logic [31:0] REC_LOAD = 32'(REC_CYCLES - 1);
  localparam logic [16:0] OSC_TOP = 17'(OSC_HZ);
  localparam logic [16:0] HUND_STEP = 17'(RTCB_HUND_PER_S);
  logic osc_m, osc_s, osc_d, sup_m, sup_s, sup_d;
  logic [63:0] cnt, buf_t, cnt_inc;
  logic [7:0] regs [RTCB_NUM_REGS];
  logic [15:0] div_acc;
  logic [16:0] div_sum;
  logic osc_edge, tick, dirty, copy_back, freeze_update_bit, osc_fail_flag;
  logic s_start, s_end, s_pload, s_pinc, s_wr, backup_entry;
  logic [31:0] ctrl, fail_limit, idle_cnt, rec_cnt;
  logic aw_got, w_got, do_write, osc_stop_ctl, osc_fail_irq_enable;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  // pin synchronisers: the first stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (rst) begin
      {osc_d, osc_s, osc_m, sup_d, sup_s, sup_m} <= 6'h00;
    end else begin
      {osc_d, osc_s, osc_m} <= {osc_s, osc_m, osc_in};
      {sup_d, sup_s, sup_m} <= {sup_s, sup_m, supply_ok_in};
    end
  end

  assign osc_stop_ctl = cnt[8 + RTCB_STOP_BIT];
  assign osc_fail_irq_enable = regs[RTCB_A_WDOG - 5'd8][RTCB_OSC_FAIL_IRQ_ENABLE_BIT];
  assign osc_edge = osc_s && !osc_d;
  assign backup_entry = sup_d && !sup_s;
  // serial requests only count while the supply is good
  assign s_start = xfer_start && sup_s;
  assign s_end = xfer_end && sup_s;
  assign s_pload = ptr_load && sup_s;
  assign s_pinc = ptr_inc && sup_s;
  assign s_wr = wr_stb && sup_s;
  // dirty can only be set by a write to 00h..07h, so it also marks a clock write transfer
  assign copy_back = dirty && (s_end || (s_pinc && ptr == RTCB_A_YEAR));

  // fractional divider: 100 hundredths per OSC_HZ oscillator periods
  assign div_sum = {1'b0, div_acc} + HUND_STEP;
  assign tick = osc_edge && !osc_stop_ctl && div_sum >= OSC_TOP;

  always_ff @(posedge core_clk) begin
    if (rst || copy_back) begin
      div_acc <= 16'h0000;
    end else if (osc_edge && !osc_stop_ctl) begin
      div_acc <= tick ? 16'(div_sum - OSC_TOP) : div_sum[15:0];
    end
  end

  rtcb_time_inc u_inc (
    .time_in(cnt),
    .time_out(cnt_inc)
  );

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt <= RTCB_TIME_RST;
    end else if (copy_back) begin
      cnt <= buf_t;
    end else if (tick) begin
      cnt <= cnt_inc;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      buf_t <= RTCB_TIME_RST;
    end else if (s_start && !freeze_update_bit) begin
      buf_t <= cnt;
    end else if (s_wr && ptr <= RTCB_A_YEAR) begin
      buf_t[ptr[2:0]*8 +: 8] <= wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || !sup_s) begin
      dirty <= 1'b0;
    end else if (s_wr && ptr <= RTCB_A_YEAR) begin
      dirty <= 1'b1;
    end else if (copy_back || s_start) begin
      dirty <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || !sup_s) begin
      ptr <= 5'h00;
    end else if (s_pload) begin
      ptr <= ptr_val;
    end else if (s_pinc) begin
      ptr <= ptr + 5'd1;
    end
  end

  // plain storage for 08h..1Fh; a few bits live in flops of their own
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < RTCB_NUM_REGS; i++) begin
        regs[i] <= RTCB_REG_RST;
      end
    end else if (s_wr && ptr > RTCB_A_YEAR) begin
      regs[ptr - 5'd8] <= wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      freeze_update_bit <= 1'b0;
    end else if (backup_entry) begin
      freeze_update_bit <= 1'b1;
    end else if (s_wr && ptr == RTCB_A_AL1H) begin
      freeze_update_bit <= wr_data[RTCB_FREEZE_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else if (ptr <= RTCB_A_YEAR) begin
      rd_data <= buf_t[ptr[2:0]*8 +: 8];
    end else if (ptr == RTCB_A_AL1H) begin
      rd_data <= {regs[ptr - 5'd8][7], freeze_update_bit,
                  regs[ptr - 5'd8][5:0]};
    end else if (ptr == RTCB_A_FLAGS) begin
      rd_data <= {regs[ptr - 5'd8][7:3], osc_fail_flag,
                  regs[ptr - 5'd8][1:0]};
    end else begin
      rd_data <= regs[ptr - 5'd8];
    end
  end

  // oscillator fail detector: no edge for fail_limit core cycles
  always_ff @(posedge core_clk) begin
    if (rst || osc_edge || osc_stop_ctl || !ctrl[0]) begin
      idle_cnt <= 32'h0000_0000;
    end else if (idle_cnt < fail_limit) begin
      idle_cnt <= idle_cnt + 32'd1;
    end
  end

  // a failure seen in the clearing cycle still wins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      osc_fail_flag <= 1'b0;
    end else if (ctrl[0] && idle_cnt >= fail_limit) begin
      osc_fail_flag <= 1'b1;
    end else if (s_wr && ptr == RTCB_A_FLAGS && !wr_data[RTCB_OFAIL_BIT]) begin
      osc_fail_flag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      osc_fail_irq_n <= 1'b1;
    end else begin
      osc_fail_irq_n <= !(osc_fail_flag && osc_fail_irq_enable);
    end
  end

  // open-drain reset pin; serial access does not wait for it
  always_ff @(posedge core_clk) begin
    rst_pin_o <= 1'b0;
    if (rst) begin
      rec_cnt <= REC_LOAD;
      rst_pin_oe <= 1'b1;
    end else begin
      if (!sup_s) begin
        rec_cnt <= REC_LOAD;
      end else if (rec_cnt != 32'h0000_0000) begin
        rec_cnt <= rec_cnt - 32'd1;
      end
      rst_pin_oe <= !sup_s || rec_cnt != 32'h0000_0000;
    end
  end

  // AXI4-Lite slave, one write and one read in flight
  assign do_write = aw_got && w_got && !s_axi_bvalid;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      aw_got <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_got <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_got <= 1'b0;
    end else if (!aw_got && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_wready <= 1'b0;
      w_got <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_got <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_got <= 1'b0;
    end else if (!w_got && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RTCB_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr == RTCB_R_CTRL || aw_addr == RTCB_R_FAIL_LIMIT) begin
        s_axi_bresp <= RTCB_RESP_OKAY;
      end else begin
        s_axi_bresp <= RTCB_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl <= RTCB_CTRL_RST;
      fail_limit <= RTCB_FAIL_LIMIT_RST;
    end else if (do_write) begin
      if (aw_addr == RTCB_R_CTRL && w_strb[0]) begin
        ctrl <= {31'h0000_0000, w_data[0]};
      end else if (aw_addr == RTCB_R_FAIL_LIMIT) begin
        for (int b = 0; b < 4; b++) begin
          if (w_strb[b]) begin
            fail_limit[b*8 +: 8] <= w_data[b*8 +: 8];
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RTCB_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RTCB_RESP_OKAY;
      if (s_axi_araddr == RTCB_R_CTRL) begin
        s_axi_rdata <= ctrl;
      end else if (s_axi_araddr == RTCB_R_STATUS) begin
        s_axi_rdata <= {25'h000_0000, dirty, rst_pin_oe, osc_stop_ctl,
                        osc_fail_flag, freeze_update_bit, !sup_s, sup_s};
      end else if (s_axi_araddr == RTCB_R_FAIL_LIMIT) begin
        s_axi_rdata <= fail_limit;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RTCB_RESP_SLVERR;
      end
    end else if (s_axi_rvalid) begin
      s_axi_rvalid <= !s_axi_rready;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end
endmodule : rtcb_core

// ===== hw/rtcb_pkg.sv
package rtcb_pkg;
  // counter/buffer and register addresses on the serial side
  localparam logic [4:0] RTCB_A_HUND = 5'h00;
  localparam logic [4:0] RTCB_A_SEC = 5'h01;
  localparam logic [4:0] RTCB_A_HOUR = 5'h03;
  localparam logic [4:0] RTCB_A_DAY = 5'h04;
  localparam logic [4:0] RTCB_A_YEAR = 5'h07;
  localparam logic [4:0] RTCB_A_WDOG = 5'h09;
  localparam logic [4:0] RTCB_A_AL1H = 5'h0C;
  localparam logic [4:0] RTCB_A_FLAGS = 5'h0F;
  localparam logic [4:0] RTCB_A_LAST = 5'h1F;
  localparam int RTCB_NUM_TIME = 8;
  localparam int RTCB_NUM_REGS = 24;
  // field positions
  localparam int RTCB_STOP_BIT = 7;
  localparam int RTCB_CENT_LSB = 6;
  localparam int RTCB_CENT_MSB = 7;
  localparam int RTCB_FREEZE_BIT = 6;
  localparam int RTCB_OFAIL_BIT = 2;
  localparam int RTCB_OSC_FAIL_IRQ_ENABLE_BIT = 7;
  // time after reset: 00.00 s, 00:00, day 1, 01/01/00, century 0
  localparam logic [63:0] RTCB_TIME_RST = 64'h0001_0101_0000_0000;
  localparam logic [7:0] RTCB_REG_RST = 8'h00;
  // timing
  localparam longint RTCB_CLK_HZ = 250_000_000;
  localparam longint RTCB_T_REC_MS = 210;
  localparam longint RTCB_REC_CYCLES = RTCB_T_REC_MS * RTCB_CLK_HZ / 1000;
  localparam int RTCB_OSC_HZ = 32_768;
  localparam int RTCB_HUND_PER_S = 100;
  // software register map (byte addresses)
  localparam logic [7:0] RTCB_R_CTRL = 8'h00;
  localparam logic [7:0] RTCB_R_STATUS = 8'h04;
  localparam logic [7:0] RTCB_R_FAIL_LIMIT = 8'h08;
  localparam logic [31:0] RTCB_CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] RTCB_FAIL_LIMIT_RST = 32'h0000_8000;
  localparam logic [1:0] RTCB_RESP_OKAY = 2'h0;
  localparam logic [1:0] RTCB_RESP_SLVERR = 2'h2;
endpackage : rtcb_pkg

// ===== hw/rtcb_time_inc.sv
`timescale 1ns/1ps
// one hundredth-second step of the BCD calendar, purely combinational
module rtcb_time_inc
  import rtcb_pkg::*;
(
  input wire logic [63:0] time_in,
  output logic [63:0] time_out
);
  function automatic logic [7:0] bcd_step(input logic [7:0] v,
                                          input logic [7:0] top,
                                          input logic [7:0] first);
    logic [7:0] r;
    r = v;
    if (v >= top) begin
      r = first;
    end else if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction : bcd_step

  logic [7:0] hund, sec, mins, hour, day, date, mon, year;
  logic [7:0] last_date;
  logic [7:0] next_sec, next_min, next_hour, next_date, next_mon;
  logic leap;
  logic c0, c1, c2, c3, c4, c5, c6;

  always_comb begin
    {year, mon, date, day, hour, mins, sec, hund} = time_in;
    // year multiple of four: tens parity and units combine mod 4
    leap = ({3'b000, year[4], 1'b0} + year[3:0]) % 4'd4 == 4'd0;
    case ({3'b000, mon[4:0]})
      8'h02: last_date = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last_date = 8'h30;
      default: last_date = 8'h31;
    endcase
    c0 = hund == 8'h99;
    c1 = c0 && sec[6:0] == 7'h59;
    c2 = c1 && mins[6:0] == 7'h59;
    c3 = c2 && hour[5:0] == 6'h23;
    c4 = c3 && date[5:0] >= last_date[5:0];
    c5 = c4 && mon[4:0] == 5'h12;
    c6 = c5 && year == 8'h99;
    next_sec = bcd_step({1'b0, sec[6:0]}, 8'h59, 8'h00);
    next_min = bcd_step({1'b0, mins[6:0]}, 8'h59, 8'h00);
    next_hour = bcd_step({2'b00, hour[5:0]}, 8'h23, 8'h00);
    next_date = bcd_step({2'b00, date[5:0]}, last_date, 8'h01);
    next_mon = bcd_step({3'b000, mon[4:0]}, 8'h12, 8'h01);
    time_out = time_in;
    time_out[7:0] = bcd_step(hund, 8'h99, 8'h00);
    if (c0) begin
      time_out[14:8] = next_sec[6:0];
    end
    if (c1) begin
      time_out[22:16] = next_min[6:0];
    end
    if (c2) begin
      time_out[29:24] = next_hour[5:0];
    end
    if (c3) begin
      time_out[34:32] = (day[2:0] >= 3'd7) ? 3'd1 : day[2:0] + 3'd1;
      time_out[45:40] = next_date[5:0];
    end
    if (c4) begin
      time_out[52:48] = next_mon[4:0];
    end
    if (c5) begin
      time_out[63:56] = bcd_step(year, 8'h99, 8'h00);
    end
    if (c6) begin
      time_out[31:30] = hour[7:6] + 2'd1;
    end
  end
endmodule : rtcb_time_inc

// ===== testbench/rtcb_core_bench.sv
`timescale 1ns/1ps
module rtcb_core_bench
  import rtcb_pkg::*;
;
  localparam int REC = 20;
  logic core_clk = 1'b0, rst = 1'b1, osc_in = 1'b0, supply_ok_in = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, rst_pin_o, rst_pin_oe, osc_fail_irq_n;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic xfer_start, xfer_end, ptr_load, ptr_inc, wr_stb;
  logic [4:0] ptr_val, ptr;
  logic [7:0] wr_data, rd_data;
  int error_cnt = 0, n_tests = 0;
  rtcb_core #(.REC_CYCLES(REC), .OSC_HZ(100)) u_dut (.core_clk, .rst,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .osc_in, .supply_ok_in, .rst_pin_o, .rst_pin_oe,
    .osc_fail_irq_n, .xfer_start, .xfer_end, .ptr_load, .ptr_val,
    .ptr_inc, .wr_stb, .wr_data, .rd_data, .ptr);
  rtcb_host u_host (.core_clk, .rd_data, .xfer_start, .xfer_end,
    .ptr_load, .ptr_val, .ptr_inc, .wr_stb, .wr_data);
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid) begin
        check("bresp", s_axi_bresp, RTCB_RESP_OKAY);
        s_axi_bready <= 1'b0;
      end
    end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rready && s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end while (s_axi_arvalid || s_axi_rready);
  endtask : axi_rd
  // oscillator edges, driven on core_clk edges; still between bursts
  task automatic osc(input int n);
    repeat (n) begin
      repeat (10) @(posedge core_clk);
      osc_in <= 1'b1;
      repeat (10) @(posedge core_clk);
      osc_in <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
  endtask : osc
  task automatic supply(input logic v);
    @(posedge core_clk);
    supply_ok_in <= v;
    repeat (8) @(posedge core_clk);
  endtask : supply
  initial begin
    #100_000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    logic [7:0] b;
    logic [31:0] d;
    logic [1:0] r;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    axi_rd(RTCB_R_CTRL, d, r);
    check("ctrl", d, RTCB_CTRL_RST);
    axi_rd(RTCB_R_FAIL_LIMIT, d, r);
    check("limit", d, RTCB_FAIL_LIMIT_RST);
    axi_rd(8'h40, d, r);
    check("unmapped", r, RTCB_RESP_SLVERR);
    check("oe_low", rst_pin_oe, 1'b1);
    supply(1'b1);
    u_host.get(RTCB_A_DAY, b);
    check("day", b, 8'h01);
    check("oe_rec", rst_pin_oe, 1'b1);
    repeat (REC) @(posedge core_clk);
    check("oe_rel", rst_pin_oe, 1'b0);
    u_host.put(RTCB_A_SEC, 8'h80);
    u_host.put(RTCB_A_SEC, 8'h22);
    u_host.get(RTCB_A_SEC, b);
    check("sec", b, 8'h22);
    u_host.get(RTCB_A_YEAR, b);
    check("year", b, 8'h00);
    osc(5);
    u_host.get(RTCB_A_HUND, b);
    check("tick", b, 8'h05);
    u_host.put(RTCB_A_SEC, 8'ha2);
    axi_rd(RTCB_R_STATUS, d, r);
    check("stop_st", d[4], 1'b1);
    osc(3);
    u_host.get(RTCB_A_HUND, b);
    check("stopped", b, 8'h05);
    u_host.put(RTCB_A_SEC, 8'h22);
    osc(2);
    // a tick inside a non-clock write must survive its end
    u_host.beat(0, 8'h00);
    u_host.beat(1, 8'h1f);
    u_host.beat(2, 8'h5a);
    osc(1);
    u_host.beat(4, 8'h00);
    u_host.get(RTCB_A_HUND, b);
    check("upper", b, 8'h08);
    // write year then step past 07h; the step copies the buffer back
    u_host.beat(0, 8'h00);
    u_host.beat(1, 8'h07);
    u_host.beat(2, 8'h05);
    u_host.beat(3, 8'h00);
    u_host.get(RTCB_A_YEAR, b);
    check("wrap", b, 8'h05);
    supply(1'b0);
    check("ptr", ptr, 5'h00);
    check("oe_bk", rst_pin_oe, 1'b1);
    u_host.put(RTCB_A_SEC, 8'h33);
    osc(3);
    supply(1'b1);
    axi_rd(RTCB_R_STATUS, d, r);
    check("frz_st", d[2], 1'b1);
    u_host.get(RTCB_A_HUND, b);
    check("frozen", b, 8'h08);
    u_host.get(RTCB_A_SEC, b);
    check("ignored", b, 8'h22);
    u_host.put(RTCB_A_AL1H, 8'h00);
    u_host.get(RTCB_A_HUND, b);
    check("thawed", b, 8'h11);
    u_host.put(RTCB_A_WDOG, 8'h80);
    axi_wr(RTCB_R_FAIL_LIMIT, 32'h0000_0010);
    repeat (40) @(posedge core_clk);
    check("irq", osc_fail_irq_n, 1'b0);
    u_host.get(RTCB_A_FLAGS, b);
    check("flag", b[2], 1'b1);
    axi_wr(RTCB_R_CTRL, 32'h0000_0000);
    u_host.put(RTCB_A_FLAGS, 8'h00);
    check("irq_clr", osc_fail_irq_n, 1'b1);
    // only byte lane 1 of the limit may change
    s_axi_wstrb <= 4'h2;
    axi_wr(RTCB_R_FAIL_LIMIT, 32'hffff_ffff);
    s_axi_wstrb <= 4'hf;
    axi_rd(RTCB_R_FAIL_LIMIT, d, r);
    check("strb", d, 32'h0000_ff10);
    give_verdict();
  end
endmodule : rtcb_core_bench
bind rtcb_core rtcb_core_sva #(.REC_CYCLES(REC_CYCLES)) u_sva (.core_clk,
  .rst, .supply_ok_in, .rst_pin_o, .rst_pin_oe, .ptr_load, .ptr_val,
  .ptr_inc, .ptr, .xfer_end);

// ===== testbench/rtcb_core_sva.sv
`timescale 1ns/1ps
module rtcb_core_sva #(
  parameter longint REC_CYCLES = 20
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic supply_ok_in,
  input wire logic rst_pin_o,
  input wire logic rst_pin_oe,
  input wire logic ptr_load,
  input wire logic [4:0] ptr_val,
  input wire logic ptr_inc,
  input wire logic [4:0] ptr,
  input wire logic xfer_end
);
  // raw cycles of good supply; saturates so long runs cannot wrap
  logic [31:0] hi_cnt;
  always_ff @(posedge core_clk) begin
    if (rst || !supply_ok_in) begin
      hi_cnt <= 32'h0000_0000;
    end else if (hi_cnt != 32'hffff_ffff) begin
      hi_cnt <= hi_cnt + 32'h0000_0001;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  property p_pin_data;
    !rst_pin_o;
  endproperty
  a_pin_data: assert property (p_pin_data) else $error("pin data");
  property p_oe_low;
    !supply_ok_in [*5] |-> rst_pin_oe;
  endproperty
  a_oe_low: assert property (p_oe_low) else $error("pin idle");
  // sync delay plus the recovery count, with a little slack
  property p_oe_fall;
    $fell(rst_pin_oe) |-> hi_cnt >= REC_CYCLES && hi_cnt <= REC_CYCLES + 5;
  endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("early");
  property p_oe_rel;
    hi_cnt == REC_CYCLES + 6 |-> !rst_pin_oe;
  endproperty
  a_oe_rel: assert property (p_oe_rel) else $error("late");
  property p_ptr_clr;
    !supply_ok_in [*5] |-> ptr == 5'h00;
  endproperty
  a_ptr_clr: assert property (p_ptr_clr) else $error("ptr kept");
  property p_ignore;
    !supply_ok_in [*5] ##0 (ptr_load || ptr_inc) |=> ptr == 5'h00;
  endproperty
  a_ignore: assert property (p_ignore) else $error("taken");
  property p_load;
    supply_ok_in [*4] ##0 ptr_load |=> ptr == $past(ptr_val);
  endproperty
  a_load: assert property (p_load) else $error("no load");
  property p_inc;
    supply_ok_in [*4] ##0 (ptr_inc && !ptr_load) |=> ptr == $past(ptr) + 5'h01;
  endproperty
  a_inc: assert property (p_inc) else $error("no inc");
  c_rel: cover property ($fell(rst_pin_oe));
  c_end: cover property (xfer_end);
  c_wrap: cover property (ptr_inc && ptr == 5'h07);
endmodule : rtcb_core_sva

// ===== testbench/rtcb_host.sv
`timescale 1ns/1ps
// behavioural host: issues the serial engine's pulses one at a time
module rtcb_host (
  input wire logic core_clk,
  input wire logic [7:0] rd_data,
  output logic xfer_start,
  output logic xfer_end,
  output logic ptr_load,
  output logic [4:0] ptr_val,
  output logic ptr_inc,
  output logic wr_stb,
  output logic [7:0] wr_data
);
  initial begin
    {xfer_start, xfer_end, ptr_load, ptr_inc, wr_stb} = 5'h00;
    ptr_val = 5'h00;
    wr_data = 8'h00;
  end
  // k: 0 start, 1 load, 2 write, 3 inc, 4 end; idle data keeps moving
  task automatic beat(input int k, input logic [7:0] d);
    @(posedge core_clk);
    xfer_start <= (k == 0);
    ptr_load <= (k == 1);
    wr_stb <= (k == 2);
    ptr_inc <= (k == 3);
    xfer_end <= (k == 4);
    ptr_val <= (k == 1) ? d[4:0] : ~ptr_val;
    wr_data <= (k == 2) ? d : ~wr_data;
    @(posedge core_clk);
    {xfer_start, xfer_end, ptr_load, ptr_inc, wr_stb} <= 5'h00;
  endtask : beat
  task automatic put(input logic [4:0] a, input logic [7:0] d);
    beat(0, 8'h00);
    beat(1, {3'h0, a});
    beat(2, d);
    beat(3, 8'h00);
    beat(4, 8'h00);
  endtask : put
  // each read is its own transfer, so it sees a fresh snapshot unless the freeze bit is set
  task automatic get(input logic [4:0] a, output logic [7:0] d);
    beat(0, 8'h00);
    beat(1, {3'h0, a});
    repeat (2) @(posedge core_clk);
    d = rd_data;
    beat(4, 8'h00);
  endtask : get
endmodule : rtcb_host
